// [src/txcmd_consts.svh]
// constants for the transmit command parser: field positions, codes, resets
// assumes inclusion by bare name from design files
`ifndef TXCMD_CONSTS_SVH
`define TXCMD_CONSTS_SVH
`define CMDA_IOC_BIT      31
`define CMDA_RSVD_HI      30
`define CMDA_RSVD_LO      26
`define CMDA_ALIGN_HI     25
`define CMDA_ALIGN_LO     24
`define CMDA_OFFSET_HI    20
`define CMDA_OFFSET_LO    16
`define CMDA_FIRST_BIT    13
`define CMDA_LAST_BIT     12
`define CMDA_SIZE_HI      10
`define CMDA_SIZE_LO      0
`define CMDB_TAG_HI       31
`define CMDB_TAG_LO       16
`define CMDB_LEN_HI       10
`define CMDB_LEN_LO       0
`define ALIGN_4           2'h0
`define ALIGN_16          2'h1
`define ALIGN_32          2'h2
`define ALIGN_MASK_4      6'h03
`define ALIGN_MASK_16     6'h0f
`define ALIGN_MASK_32     6'h1f
`define TAG_RESET         16'h0000
`endif

// [src/txcmd_pkg.sv]
// types shared by the transmit command parser modules
// assumes nothing beyond a SystemVerilog compiler
package txcmd_pkg;
  // parser phase within one buffer, one-hot
  typedef enum logic [3:0] {
    ST_CMDA = 4'b0001,
    ST_CMDB = 4'b0010,
    ST_DATA = 4'b0100,
    ST_PAD  = 4'b1000
  } phase_t;
endpackage : txcmd_pkg

// [src/word_lane_if.sv]
// interface carrying one host word's byte position and its byte-lane keep mask
// assumes a single clock domain shared by both ends
`timescale 1ns/1ps
`default_nettype none
interface word_lane_if;
  logic [11:0] start_byte;   // byte index of this word within the buffer
  logic [4:0]  offset;
  logic [11:0] end_byte;     // offset + size
  logic [3:0]  keep;
  logic        any;
  modport src (output start_byte, offset, end_byte, input keep, any);
  modport sink (input start_byte, offset, end_byte, output keep, any);
endinterface : word_lane_if
`default_nettype wire

// [src/byte_keep.sv]
// byte-lane selector: marks which bytes of a word are payload
// assumes the buffer's byte window is [offset, offset+size)
`timescale 1ns/1ps
`default_nettype none
module byte_keep (
  word_lane_if.sink lane
);
  // ================================================================
  // per-lane window check
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_lane
      logic [11:0] pos;
      assign pos = lane.start_byte + 12'(g);
      assign lane.keep[g] = (pos >= {7'h00, lane.offset}) && (pos < lane.end_byte);
    end
  endgenerate
  assign lane.any = |lane.keep;
endmodule : byte_keep
`default_nettype wire

// [src/tx_buffer_command_parser.sv]
// transmit command parser: decodes command pair, strips offset and padding
// assumes host writes one 32-bit word per wr_valid pulse on ref_clk
// What this block does
// - each buffer begins with exactly two 32-bit command words
// - second command word must match across a packet; mismatch raises error
// - 16-bit tag from second word is returned with packet status
// - completion bit set raises done flag once buffer fully loaded
// - done flag may be routed to host interrupt under host enable
// - bits 25:24 select end alignment of 4, 16 or 32 bytes
// - padding words are discarded, never passed as data
// - bits 20:16 give start offset; earlier bytes are dropped
// - bit 13 marks first segment, bit 12 marks last segment
// - sum buffer sizes over packet; mismatch with length raises error
`timescale 1ns/1ps
`default_nettype none
`include "txcmd_consts.svh"
module tx_buffer_command_parser (
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  input  wire logic        wr_valid,
  input  wire logic [31:0] wr_data,
  input  wire logic        done_irq_enable,
  output var  logic        data_valid_reg,
  output var  logic [31:0] data_word_reg,
  output var  logic [3:0]  data_keep_reg,
  output var  logic        data_last_reg,
  output var  logic        tx_error_flag,
  output var  logic        tx_buffer_done_flag,
  output var  logic        done_irq_reg,
  output var  logic        tag_valid_reg,
  output var  logic [15:0] tag_reg
);
  import txcmd_pkg::*;

  // ================================================================
  // reset release through two flops
  logic rst_meta_reg;
  logic rst_sync_reg;
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end
  wire logic rst_n;
  assign rst_n = rst_sync_reg;

  // ================================================================
  // command state
  phase_t      phase_reg;
  logic [31:0] cmda_reg;
  logic [31:0] cmdb_reg;
  logic [31:0] pkt_cmdb_reg;      // command B of the first segment
  logic        in_packet_reg;
  logic [12:0] pkt_sum_reg;
  logic [9:0]  word_idx_reg;      // words consumed after command B
  logic [9:0]  total_words;       // payload plus padding words

  // ================================================================
  // buffer geometry from command A
  logic [11:0] end_byte;
  logic [9:0]  data_words;
  logic [5:0]  align_mask;
  logic [11:0] pad_end;
  always_comb begin
    end_byte = {7'h00, cmda_reg[`CMDA_OFFSET_HI:`CMDA_OFFSET_LO]}
             + {1'b0, cmda_reg[`CMDA_SIZE_HI:`CMDA_SIZE_LO]};
    data_words = 10'((end_byte + 12'h003) >> 2);
    unique case (cmda_reg[`CMDA_ALIGN_HI:`CMDA_ALIGN_LO])
      `ALIGN_16: align_mask = `ALIGN_MASK_16;
      `ALIGN_32: align_mask = `ALIGN_MASK_32;
      default:   align_mask = `ALIGN_MASK_4;   // reserved code falls back to word alignment
    endcase
    // padding rounds buffer end up; reserved bits never read
    pad_end = (end_byte + {6'h00, align_mask}) & ~{6'h00, align_mask};
    total_words = 10'(pad_end >> 2);
  end

  // ================================================================
  // byte lane selection
  word_lane_if lane ();
  // full 12-bit byte index: offset plus a long buffer passes byte 2047
  assign lane.start_byte = {word_idx_reg, 2'b00};
  assign lane.offset     = cmda_reg[`CMDA_OFFSET_HI:`CMDA_OFFSET_LO];
  assign lane.end_byte   = end_byte;
  byte_keep u_keep (
    .lane (lane)
  );

  wire logic last_word;
  assign last_word = (word_idx_reg + 10'h001 == total_words);
  wire logic last_data;
  assign last_data = (word_idx_reg + 10'h001 == data_words);

  // ================================================================
  // buffer sequencer
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_reg    <= ST_CMDA;
      word_idx_reg <= 10'h000;
    end else if (wr_valid) begin
      unique case (phase_reg)
        ST_CMDA: phase_reg <= ST_CMDB;
        ST_CMDB: begin
          word_idx_reg <= 10'h000;
          phase_reg    <= (total_words == 10'h000) ? ST_CMDA : ST_DATA;
        end
        ST_DATA, ST_PAD: begin
          word_idx_reg <= word_idx_reg + 10'h001;
          if (last_word) begin
            phase_reg <= ST_CMDA;
          end else if (last_data) begin
            phase_reg <= ST_PAD;
          end
        end
      endcase
    end
  end

  // command word capture
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmda_reg <= 32'h0000_0000;
      cmdb_reg <= 32'h0000_0000;
    end else if (wr_valid) begin
      if (phase_reg == ST_CMDA) begin
        cmda_reg <= wr_data;
      end
      if (phase_reg == ST_CMDB) begin
        cmdb_reg <= wr_data;
      end
    end
  end

  // ================================================================
  // payload output, padding and offset bytes dropped
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      data_valid_reg <= 1'b0;
      data_word_reg  <= 32'h0000_0000;
      data_keep_reg  <= 4'h0;
      data_last_reg  <= 1'b0;
    end else begin
      data_valid_reg <= wr_valid && (phase_reg == ST_DATA) && lane.any;
      data_word_reg  <= wr_data;
      data_keep_reg  <= lane.keep;
      data_last_reg  <= last_data && cmda_reg[`CMDA_LAST_BIT];
    end
  end

  // ================================================================
  // packet consistency: command B match and length sum
  logic cmdb_event;
  logic buf_end;
  assign cmdb_event = wr_valid && (phase_reg == ST_CMDB);
  assign buf_end = (cmdb_event && total_words == 10'h000)
                 || (wr_valid && (phase_reg == ST_DATA || phase_reg == ST_PAD) && last_word);
  wire logic first_seg;
  assign first_seg = cmda_reg[`CMDA_FIRST_BIT];
  logic [12:0] sum_now;
  assign sum_now = (first_seg ? 13'h0000 : pkt_sum_reg)
                 + {2'h0, cmda_reg[`CMDA_SIZE_HI:`CMDA_SIZE_LO]};
  logic mismatch;
  assign mismatch = !first_seg && in_packet_reg && (wr_data != pkt_cmdb_reg);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      in_packet_reg <= 1'b0;
      pkt_cmdb_reg  <= 32'h0000_0000;
      pkt_sum_reg   <= 13'h0000;
      tx_error_flag <= 1'b0;
    end else begin
      if (cmdb_event) begin
        if (first_seg) begin
          pkt_cmdb_reg <= wr_data;
        end
        pkt_sum_reg   <= sum_now;
        in_packet_reg <= !cmda_reg[`CMDA_LAST_BIT];
        if (mismatch) begin
          tx_error_flag <= 1'b1;
        end
        if (cmda_reg[`CMDA_LAST_BIT] &&
            sum_now != {2'h0, wr_data[`CMDB_LEN_HI:`CMDB_LEN_LO]}) begin
          tx_error_flag <= 1'b1;
        end
      end
    end
  end

  // ================================================================
  // tag handoff and completion flag
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tag_reg       <= `TAG_RESET;
      tag_valid_reg <= 1'b0;
    end else begin
      // tag to status at packet end
      tag_valid_reg <= buf_end && cmda_reg[`CMDA_LAST_BIT];
      // empty buffer ends on command B itself, before cmdb_reg holds it
      if (buf_end && cmda_reg[`CMDA_LAST_BIT]) begin
        tag_reg <= cmdb_event ? wr_data[`CMDB_TAG_HI:`CMDB_TAG_LO]
                              : cmdb_reg[`CMDB_TAG_HI:`CMDB_TAG_LO];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_buffer_done_flag <= 1'b0;
      done_irq_reg        <= 1'b0;
    end else begin
      tx_buffer_done_flag <= buf_end && cmda_reg[`CMDA_IOC_BIT];
      done_irq_reg <= buf_end && cmda_reg[`CMDA_IOC_BIT] && done_irq_enable;
    end
  end
endmodule : tx_buffer_command_parser
`default_nettype wire

// [test/host_model.sv]
// host-side word writer driving the parser's write strobe
// assumes calls start just after a rising edge of ref_clk
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input  wire logic        ref_clk,
  output var  logic        wr_valid,
  output var  logic [31:0] wr_data
);
  initial begin
    wr_valid = 1'b0;
    wr_data  = 32'h0;
  end
  // callers send a, b, payload, pad words in order
  task send(input logic [31:0] w);
    wr_valid = 1'b1;
    wr_data  = w;
    @(posedge ref_clk);
    #1;
  endtask : send
  // released bus shows the inverse so a stale word is never mistaken
  task idle();
    wr_valid = 1'b0;
    wr_data  = ~wr_data;
  endtask : idle
endmodule : host_model
`default_nettype wire

// [test/tx_buffer_command_parser_assertions.sv]
// port-level checks of the transmit command parser
// assumes binding onto tx_buffer_command_parser
`timescale 1ns/1ps
`default_nettype none
module txcmd_checker (
  input wire logic        ref_clk,
  input wire logic        rst_b,
  input wire logic        wr_valid,
  input wire logic        done_irq_enable,
  input wire logic        data_valid_reg,
  input wire logic [3:0]  data_keep_reg,
  input wire logic        tx_error_flag,
  input wire logic        tx_buffer_done_flag,
  input wire logic        done_irq_reg,
  input wire logic        tag_valid_reg,
  input wire logic [15:0] tag_reg
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  error_sticky_a: assert property (tx_error_flag |=> tx_error_flag) else $error("error flag dropped");
  done_pulse_a: assert property (tx_buffer_done_flag |=> !tx_buffer_done_flag) else $error("done too long");
  irq_route_a: assert property (done_irq_reg |-> tx_buffer_done_flag) else $error("irq without done");
  irq_enable_a: assert property (tx_buffer_done_flag && $past(done_irq_enable) |-> done_irq_reg)
    else $error("irq missing");
  tag_hold_a: assert property (!tag_valid_reg |-> $stable(tag_reg)) else $error("tag moved");
  keep_nonzero_a: assert property (data_valid_reg |-> data_keep_reg != 4'h0) else $error("empty keep");
  data_cause_a: assert property (data_valid_reg |-> $past(wr_valid)) else $error("data without write");
  done_cause_a: assert property (tx_buffer_done_flag |-> $past(wr_valid)) else $error("done without write");
  tag_cause_a: assert property (tag_valid_reg |-> $past(wr_valid)) else $error("tag without write");
  error_cause_a: assert property ($rose(tx_error_flag) |-> $past(wr_valid)) else $error("error without write");
endmodule : txcmd_checker
bind tx_buffer_command_parser txcmd_checker u_txcmd_checker (.ref_clk(ref_clk), .rst_b(rst_b), .wr_valid(wr_valid),
  .done_irq_enable(done_irq_enable), .data_valid_reg(data_valid_reg), .data_keep_reg(data_keep_reg),
  .tx_error_flag(tx_error_flag), .tx_buffer_done_flag(tx_buffer_done_flag), .done_irq_reg(done_irq_reg),
  .tag_valid_reg(tag_valid_reg), .tag_reg(tag_reg));
`default_nettype wire

// [test/tx_buffer_command_parser_bench.sv]
// self-checking bench: buffers sent through host_model, bytes compared
// assumes design files and host_model compiled first
`timescale 1ns/1ps
`default_nettype none
module tx_buffer_command_parser_bench;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic done_irq_enable = 1'b0;
  logic wr_valid, dv, dl, err, done, irq, tv;
  logic [31:0] wr_data, dw;
  logic [3:0] dk;
  logic [15:0] tag;
  int n_errors = 0;
  int comparisons = 0;
  int n_done = 0, n_irq = 0, n_tagv = 0, n_last = 0;
  logic [7:0] exp_q[$], got_q[$];
  initial forever #5 ref_clk = ~ref_clk;
  host_model u_host_model (.ref_clk(ref_clk), .wr_valid(wr_valid), .wr_data(wr_data));
  tx_buffer_command_parser u_tx_buffer_command_parser (.ref_clk(ref_clk), .rst_b(rst_b), .wr_valid(wr_valid),
    .wr_data(wr_data), .done_irq_enable(done_irq_enable), .data_valid_reg(dv), .data_word_reg(dw),
    .data_keep_reg(dk), .data_last_reg(dl), .tx_error_flag(err), .tx_buffer_done_flag(done),
    .done_irq_reg(irq), .tag_valid_reg(tv), .tag_reg(tag));
  // gather kept bytes and count pulses as they stand for one cycle
  always @(posedge ref_clk) begin
    if (dv === 1'b1) for (int g = 0; g < 4; g++) if (dk[g] === 1'b1) got_q.push_back(dw[8*g+:8]);
    n_done += (done === 1'b1);
    n_irq  += (irq === 1'b1);
    n_tagv += (tv === 1'b1);
    n_last += (dv === 1'b1 && dl === 1'b1);
  end
  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task final_report();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : final_report
  task do_reset();
    rst_b = 1'b0;
    repeat (3) @(posedge ref_clk);
    #1 rst_b = 1'b1;
    repeat (4) @(posedge ref_clk);
    #1;
  endtask : do_reset
  // one buffer: command a, command b, payload and padding words
  task buf_send(input logic ioc, input logic [1:0] al, input logic [4:0] off, input logic [10:0] sz,
                input logic fs, input logic ls, input logic [31:0] b);
    int nb, pe;
    logic [31:0] w;
    nb = off + sz;
    pe = (al == 2'h2) ? 32 : (al == 2'h1) ? 16 : 4;
    pe = ((nb + pe - 1) / pe) * pe;
    u_host_model.send({ioc, 5'h00, al, 3'h0, off, 2'h0, fs, ls, 1'b0, sz});
    u_host_model.send(b);
    for (int k = 0; k < pe; k += 4) begin
      for (int j = 0; j < 4; j++) begin
        w[8*j+:8] = 8'(k + j) ^ 8'h5a;
        if (k + j >= off && k + j < nb) exp_q.push_back(w[8*j+:8]);
      end
      u_host_model.send(w);
    end
  endtask : buf_send
  // let the last answers land, then compare payload bytes
  task settle();
    u_host_model.idle();
    repeat (3) @(posedge ref_clk);
    #1;
    check("byte count", got_q.size(), exp_q.size());
    foreach (exp_q[i]) if (i < got_q.size()) check("byte", got_q[i], exp_q[i]);
    exp_q.delete();
    got_q.delete();
  endtask : settle
  initial begin
    repeat (5000) @(posedge ref_clk);
    n_errors++;
    final_report();
  end
  initial begin
    do_reset();
    // single buffer, offset 3, 16-byte end, reserved bits zero
    done_irq_enable = 1'b1;
    buf_send(1'b1, 2'h1, 5'd3, 11'd5, 1'b1, 1'b1, {16'h1234, 5'h0, 11'd5});
    settle();
    check("tag", tag, 32'h1234);
    check("done", n_done, 1);
    check("irq", n_irq, 1);
    check("last", n_last, 1);
    check("err", err, 1'b0);
    // two segments, 32-byte end, equal command b, irq routing off
    done_irq_enable = 1'b0;
    buf_send(1'b0, 2'h2, 5'd0, 11'd6, 1'b1, 1'b0, {16'h0005, 5'h0, 11'd10});
    buf_send(1'b1, 2'h2, 5'd1, 11'd4, 1'b0, 1'b1, {16'h0005, 5'h0, 11'd10});
    settle();
    check("done2", n_done, 2);
    check("irq2", n_irq, 1);
    check("tagv", n_tagv, 2);
    check("tag2", tag, 32'h0005);
    check("err2", err, 1'b0);
    // command b differs between segments, 4-byte end
    buf_send(1'b0, 2'h0, 5'd0, 11'd4, 1'b1, 1'b0, {16'h0007, 5'h0, 11'd8});
    buf_send(1'b0, 2'h0, 5'd0, 11'd4, 1'b0, 1'b1, {16'h0008, 5'h0, 11'd8});
    settle();
    check("err mismatch", err, 1'b1);
    do_reset();
    check("err reset", err, 1'b0);
    // empty buffer: ends on command b, tag taken from that word
    buf_send(1'b1, 2'h0, 5'd0, 11'd0, 1'b1, 1'b1, {16'h00aa, 5'h0, 11'd0});
    settle();
    check("done3", n_done, 3);
    check("tag0", tag, 32'h00aa);
    check("err0", err, 1'b0);
    // size total disagrees with packet length
    buf_send(1'b0, 2'h0, 5'd2, 11'd4, 1'b1, 1'b1, {16'h0009, 5'h0, 11'd5});
    settle();
    check("err length", err, 1'b1);
    final_report();
  end
endmodule : tx_buffer_command_parser_bench
`default_nettype wire
